// ---- logic/cipr_top.sv ----
// cpu interrupt prioritizer: three levels, static or rotating order
// assumes core gives insn_done, sleep, wake_done, ack/ret handshakes
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cipr_defs.svh"

// What this block does
// - ranks nmi highest, then one optional high vector, then normal ones
// - request is acknowledged at once or held pending until it outranks
// - high request preempts normal handler; normal resumes after return
// - nmi taken regardless of global enable and never changes it
// - nothing preempts a running nmi handler
// - simultaneous nmis served lowest vector first
// - writing a vector into high vector register promotes it
// - all non-nmi vectors are normal unless chosen as high vector
// - vector 0 is reset, 1 is nmi; those and high outrank normal
// - static mode keeps base as written; lowest pending normal vector first at base 0 or 1
// - base value y makes y lowest and y+1 highest, wrapping around
// - round robin loads base with each acknowledged normal vector
// - round robin active only while its enable bit is one
// - compact table uses vectors 1 nmi, 2 high, 3 all normal
// - taking a request never clears the peripheral flag
// - one program instruction runs after a return before next service
// - response is finish one, push two, jump three or two cycles
// - request during multi-cycle instruction waits for its completion
// - wake from sleep adds five cycles after start-up time
// - return takes four or five cycles by program counter width
// - placement bit puts table after or at start of boot section
// - high vector value zero disables the high level
// - executing flags track levels; each return clears innermost
module cipr_top #(
  parameter int          NUM_VEC   = 64,
  parameter logic [NUM_VEC-1:0] NMI_MASK = 64'h0000_0000_0000_0002,
  parameter int          FLASH_KB  = 16,
  parameter bit          WIDE_PC   = 1'b0
) (
  input  wire logic                 CLK_I,
  input  wire logic                 ARST_N_I,
  input  wire logic [NUM_VEC-1:0]   IRQ_I,
  input  wire logic                 GLOBAL_EN_I,
  input  wire logic                 INSN_DONE_I,
  input  wire logic                 SLEEP_I,
  input  wire logic                 WAKE_DONE_I,
  input  wire logic                 ACK_I,
  input  wire logic                 RET_I,
  input  wire logic [`CIPR_ADDR_W-1:0] ADDR_I,
  input  wire logic [7:0]           WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output logic [7:0]                RDATA_O,
  output logic                      REQ_O,
  output logic [7:0]                VEC_O,
  output logic [7:0]                LAST_VEC_O,
  output logic                      HANDLER_JUMP_O,
  output logic                      RET_DONE_O,
  output logic                      PLACEMENT_O
);
  import cipr_pkg::*;

  localparam int JMP_CYC = (FLASH_KB > `CIPR_SMALL_FLASH_KB) ?
                           `CIPR_CYC_JMP_LARGE : `CIPR_CYC_JMP_SMALL;
  localparam int RET_CYC = WIDE_PC ? `CIPR_CYC_RET_LONG :
                           `CIPR_CYC_RET_SHORT;

  typedef struct packed {
    cipr_state_type st;
    logic [2:0]     cnt;
    logic           slept;
    logic           rr_en;
    logic           compact;
    logic           placement;
    cipr_byte_type  base;
    cipr_byte_type  high_vec;
    logic           nmi_ex;
    logic           high_ex;
    logic           normal_ex;
    logic [2:0]     taken_lvl;
    cipr_byte_type  sel_vec;
    cipr_byte_type  sel_raw;
    logic [2:0]     sel_lvl;
    logic           req;
    logic           jump;
    logic           ret_done;
    cipr_byte_type  rdata;
  } cipr_state_rec_type;

  cipr_state_rec_type s_q;
  cipr_state_rec_type s_d;

  // rotated distance from base+1; smaller wins
  function automatic cipr_byte_type rot_dist(input cipr_byte_type v,
                                             input cipr_byte_type b);
    rot_dist = v - b - 8'h01;
  endfunction

  function automatic logic is_high(input int v, input cipr_byte_type hv);
    is_high = (hv != `CIPR_BYTE_ZERO) && (v == int'(hv));
  endfunction

  logic           nmi_hit;
  logic           high_hit;
  logic           norm_hit;
  cipr_byte_type  nmi_v;
  cipr_byte_type  norm_v;
  cipr_byte_type  norm_d;
  logic [2:0]     cur_lvl;
  logic           can_take;

  // pending requests stay live until the peripheral drops them
  always_comb begin
    nmi_hit  = 1'b0;
    high_hit = 1'b0;
    norm_hit = 1'b0;
    nmi_v    = `CIPR_BYTE_ZERO;
    norm_v   = `CIPR_BYTE_ZERO;
    norm_d   = 8'hff;
    // bit 0 is the reset vector; nmi sources start at bit 1
    for (int i = NUM_VEC - 1; i >= 1; i--) begin
      if (IRQ_I[i] && NMI_MASK[i]) begin
        nmi_hit = 1'b1;
        nmi_v   = 8'(i);
      end
    end
    for (int i = 2; i < NUM_VEC; i++) begin
      if (IRQ_I[i] && !NMI_MASK[i]) begin
        if (is_high(i, s_q.high_vec)) begin
          high_hit = 1'b1;
        end else if (rot_dist(8'(i), s_q.base) < norm_d ||
                     !norm_hit) begin
          norm_hit = 1'b1;
          norm_v   = 8'(i);
          norm_d   = rot_dist(8'(i), s_q.base);
        end
      end
    end
  end

  // level now running: 3 nmi, 2 high, 1 normal, 0 none
  always_comb begin
    if (s_q.nmi_ex) begin
      cur_lvl = 3'd3;
    end else if (s_q.high_ex) begin
      cur_lvl = 3'd2;
    end else if (s_q.normal_ex) begin
      cur_lvl = 3'd1;
    end else begin
      cur_lvl = 3'd0;
    end
  end

  // nmi ignores global enable; nothing outranks a running nmi
  always_comb begin
    can_take = 1'b0;
    if (nmi_hit && cur_lvl < 3'd3) begin
      can_take = 1'b1;
    end else if (GLOBAL_EN_I && high_hit && cur_lvl < 3'd2) begin
      can_take = 1'b1;
    end else if (GLOBAL_EN_I && norm_hit && cur_lvl < 3'd1) begin
      can_take = 1'b1;
    end
  end

  always_comb begin
    s_d          = s_q;
    s_d.jump     = 1'b0;
    s_d.ret_done = 1'b0;
    s_d.rdata    = `CIPR_BYTE_ZERO;

    if (WR_I) begin
      if (ADDR_I == `CIPR_OFF_CTRL) begin
        s_d.rr_en     = WDATA_I[`CIPR_BIT_RR];
        s_d.compact   = WDATA_I[`CIPR_BIT_COMPACT];
        s_d.placement = WDATA_I[`CIPR_BIT_PLACEMENT];
      end else if (ADDR_I == `CIPR_OFF_NORMAL_BASE) begin
        s_d.base = WDATA_I;
      end else if (ADDR_I == `CIPR_OFF_HIGH_VEC) begin
        s_d.high_vec = WDATA_I;
      end
    end
    if (RD_I) begin
      if (ADDR_I == `CIPR_OFF_CTRL) begin
        s_d.rdata[`CIPR_BIT_RR]        = s_q.rr_en;
        s_d.rdata[`CIPR_BIT_COMPACT]   = s_q.compact;
        s_d.rdata[`CIPR_BIT_PLACEMENT] = s_q.placement;
      end else if (ADDR_I == `CIPR_OFF_STATUS) begin
        s_d.rdata[`CIPR_BIT_NMI_EX]    = s_q.nmi_ex;
        s_d.rdata[`CIPR_BIT_HIGH_EX]   = s_q.high_ex;
        s_d.rdata[`CIPR_BIT_NORMAL_EX] = s_q.normal_ex;
      end else if (ADDR_I == `CIPR_OFF_NORMAL_BASE) begin
        s_d.rdata = s_q.base;
      end else if (ADDR_I == `CIPR_OFF_HIGH_VEC) begin
        s_d.rdata = s_q.high_vec;
      end
    end

    case (s_q.st)
      CIPR_IDLE: begin
        if (can_take) begin
          s_d.slept = SLEEP_I;
          // selection freezes here so the core sees a stable vector
          if (nmi_hit && cur_lvl < 3'd3) begin
            s_d.sel_lvl = 3'd3;
            s_d.sel_raw = nmi_v;
            s_d.sel_vec = s_q.compact ? `CIPR_VEC_CMP_NMI : nmi_v;
          end else if (high_hit && cur_lvl < 3'd2) begin
            s_d.sel_lvl = 3'd2;
            s_d.sel_raw = s_q.high_vec;
            s_d.sel_vec = s_q.compact ? `CIPR_VEC_CMP_HIGH :
                                        s_q.high_vec;
          end else begin
            s_d.sel_lvl = 3'd1;
            s_d.sel_raw = norm_v;
            s_d.sel_vec = s_q.compact ? `CIPR_VEC_CMP_NORMAL :
                                        norm_v;
          end
          s_d.st = CIPR_WAIT_INSN;
        end else if (RET_I && cur_lvl != 3'd0) begin
          s_d.cnt = 3'(RET_CYC - 1);
          s_d.st  = CIPR_RETURN;
        end
      end
      CIPR_WAIT_INSN: begin
        // multi-cycle instructions hold us here
        if (s_q.slept ? WAKE_DONE_I : INSN_DONE_I) begin
          s_d.cnt = s_q.slept ? 3'(`CIPR_CYC_WAKE - 1) :
                                3'(`CIPR_CYC_PUSH - 1);
          s_d.st  = s_q.slept ? CIPR_WAKE : CIPR_PUSH;
        end
      end
      CIPR_WAKE: begin
        if (s_q.cnt == 3'd0) begin
          s_d.cnt = 3'(`CIPR_CYC_PUSH - 1);
          s_d.st  = CIPR_PUSH;
        end else begin
          s_d.cnt = s_q.cnt - 3'd1;
        end
      end
      CIPR_PUSH: begin
        s_d.req = 1'b1;
        if (ACK_I && s_q.req) begin
          s_d.req = 1'b0;
          s_d.taken_lvl = s_q.sel_lvl;
          if (s_q.sel_lvl == 3'd3) begin
            s_d.nmi_ex = 1'b1;
          end else if (s_q.sel_lvl == 3'd2) begin
            s_d.high_ex = 1'b1;
          end else begin
            s_d.normal_ex = 1'b1;
            if (s_q.rr_en) begin
              s_d.base = s_q.sel_raw;
            end
          end
          s_d.cnt = 3'(JMP_CYC - 1);
          s_d.st  = CIPR_JUMP;
        end
      end
      CIPR_JUMP: begin
        if (s_q.cnt == 3'd0) begin
          s_d.jump = 1'b1;
          s_d.st   = CIPR_IDLE;
        end else begin
          s_d.cnt = s_q.cnt - 3'd1;
        end
      end
      CIPR_RETURN: begin
        if (s_q.cnt == 3'd0) begin
          // innermost level unwinds first
          if (s_q.nmi_ex) begin
            s_d.nmi_ex = 1'b0;
          end else if (s_q.high_ex) begin
            s_d.high_ex = 1'b0;
          end else begin
            s_d.normal_ex = 1'b0;
          end
          s_d.ret_done = 1'b1;
          s_d.st       = CIPR_GAP;
        end else begin
          s_d.cnt = s_q.cnt - 3'd1;
        end
      end
      CIPR_GAP: begin
        // one program instruction before new service
        if (INSN_DONE_I) begin
          s_d.st = CIPR_IDLE;
        end
      end
      default: begin
        s_d.st = CIPR_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA_O        = s_q.rdata;
  assign REQ_O          = s_q.req;
  assign VEC_O          = s_q.sel_vec;
  assign LAST_VEC_O     = s_q.sel_raw;
  assign HANDLER_JUMP_O = s_q.jump;
  assign RET_DONE_O     = s_q.ret_done;
  assign PLACEMENT_O    = s_q.placement;

endmodule

// ---- logic/cipr_defs.svh ----
// register offsets, field positions, reset values and timing counts
// for the cpu interrupt prioritizer; included by package and module
`ifndef CIPR_DEFS_SVH
`define CIPR_DEFS_SVH

`define CIPR_ADDR_W          2
`define CIPR_OFF_CTRL        2'h0
`define CIPR_OFF_STATUS      2'h1
`define CIPR_OFF_NORMAL_BASE 2'h2
`define CIPR_OFF_HIGH_VEC    2'h3

`define CIPR_BIT_RR          0
`define CIPR_BIT_COMPACT     5
`define CIPR_BIT_PLACEMENT   6
`define CIPR_BIT_NORMAL_EX   0
`define CIPR_BIT_HIGH_EX     1
`define CIPR_BIT_NMI_EX      7

`define CIPR_CTRL_RESET      8'h00
`define CIPR_BYTE_ZERO       8'h00

`define CIPR_VEC_NMI         8'h01
`define CIPR_VEC_CMP_NMI     8'h01
`define CIPR_VEC_CMP_HIGH    8'h02
`define CIPR_VEC_CMP_NORMAL  8'h03

// response timing in cycles
`define CIPR_CYC_FINISH      1
`define CIPR_CYC_PUSH        2
`define CIPR_CYC_JMP_LARGE   3
`define CIPR_CYC_JMP_SMALL   2
`define CIPR_CYC_WAKE        5
`define CIPR_CYC_RET_SHORT   4
`define CIPR_CYC_RET_LONG    5
`define CIPR_SMALL_FLASH_KB  8

`endif

// ---- logic/cipr_pkg.sv ----
// types shared by the cpu interrupt prioritizer
// assumes cipr_defs.svh is on the include path
`include "cipr_defs.svh"

package cipr_pkg;

  typedef logic [7:0] cipr_byte_type;

  typedef enum logic [2:0] {
    CIPR_IDLE,
    CIPR_WAIT_INSN,
    CIPR_WAKE,
    CIPR_PUSH,
    CIPR_JUMP,
    CIPR_RETURN,
    CIPR_GAP
  } cipr_state_type;

endpackage

// ---- tb/cipr_top_sva.sv ----
// port assertions for the interrupt prioritizer
// assumes a bind onto cipr_top from the bench top file
`timescale 1ns/1ps
module cipr_top_sva #(
  parameter int FLASH_KB = 16,
  parameter bit WIDE_PC  = 1'b0
) (
  input logic       CLK_I,
  input logic       ARST_N_I,
  input logic       ACK_I,
  input logic       RET_I,
  input logic [1:0] ADDR_I,
  input logic [7:0] WDATA_I,
  input logic       WR_I,
  input logic       RD_I,
  input logic [7:0] RDATA_O,
  input logic       REQ_O,
  input logic [7:0] VEC_O,
  input logic       HANDLER_JUMP_O,
  input logic       RET_DONE_O,
  input logic       PLACEMENT_O
);
  localparam int JB = FLASH_KB > 8 ? 4 : 3;
  localparam int JA = JB - 1;
  localparam int RL = WIDE_PC ? 5 : 4;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_req_hold: assert property (
    REQ_O && !ACK_I |=> REQ_O && $stable(VEC_O)) else $error("req lost");
  a_ack_drop: assert property (
    REQ_O && ACK_I |=> !REQ_O) else $error("req kept after ack");
  a_jump_time: assert property (
    REQ_O && ACK_I |-> ##[JA:JB] HANDLER_JUMP_O) else $error("jump late");
  a_jump_once: assert property (
    HANDLER_JUMP_O |=> !HANDLER_JUMP_O) else $error("jump too long");
  a_ret_time: assert property (
    RET_DONE_O |-> $past(RET_I, RL) || $past(RET_I, RL + 1))
    else $error("return time wrong");
  a_status_rsvd: assert property (
    RD_I && ADDR_I == 2'h1 |=> RDATA_O[6:2] == 5'h00)
    else $error("status reserved bits set");
  a_place_bit: assert property (
    WR_I && ADDR_I == 2'h0 |=> PLACEMENT_O == $past(WDATA_I[6]))
    else $error("placement not taken");
  a_vec_nonzero: assert property (
    REQ_O |-> VEC_O != 8'h00) else $error("reset vector requested");
endmodule

// ---- tb/cipr_core_model.sv ----
// cpu core stand-in: paces instructions, acks vector requests
// assumes the prioritizer core link on one clock
`timescale 1ns/1ps
module cipr_core_model (
  input  logic clk_i,
  input  logic arst_n_i,
  input  logic req_i,
  input  logic slow_i,
  output logic insn_done_o,
  output logic ack_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_q <= 2'h0;
      insn_done_o <= 1'b0;
      ack_o <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      // two-cycle insns, so requests wait for completion
      insn_done_o <= cnt_q[0];
      ack_o <= req_i && !ack_o && (!slow_i || &cnt_q);
    end
  end
endmodule

// ---- tb/test_cipr_top.sv ----
// bench for the interrupt prioritizer, one task per scenario
// assumes the core model acks requests and paces instructions
`timescale 1ns/1ps
module test_cipr_top;
  logic clk = 1'b0, arst_n = 1'b0, ge = 1'b0, ret = 1'b0;
  logic wr = 1'b0, rd = 1'b0, slow = 1'b0, ack, done;
  logic sleep = 1'b0, wake = 1'b0;
  logic req, jump, rdone, place;
  logic [63:0] irq = 64'h0;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, rdata, vec, last;
  int err_count = 0, samples_checked = 0;
  cipr_top u_dut (.CLK_I(clk), .ARST_N_I(arst_n), .IRQ_I(irq),
    .GLOBAL_EN_I(ge), .INSN_DONE_I(done), .SLEEP_I(sleep),
    .WAKE_DONE_I(wake), .ACK_I(ack), .RET_I(ret), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .REQ_O(req), .VEC_O(vec), .LAST_VEC_O(last),
    .HANDLER_JUMP_O(jump), .RET_DONE_O(rdone), .PLACEMENT_O(place));
  cipr_core_model u_core (.clk_i(clk), .arst_n_i(arst_n),
    .req_i(req), .slow_i(slow), .insn_done_o(done), .ack_o(ack));
  task automatic close_out;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [1:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("register", e, rdata);
  endtask
  // bounded wait: 0 request, 1 handler jump, 2 return done
  task automatic hold(input int s);
    for (int n = 0; n < 90; n++) begin
      @(posedge clk);
      #1;
      if ({req, jump, rdone} === 3'h4 >> s) return;
    end
    err_count++;
    close_out();
  endtask
  task automatic srv(input logic [63:0] m, input logic [7:0] v);
    @(posedge clk);
    irq <= m;
    hold(0);
    chk("vector", v, vec);
    hold(1);
  endtask
  // handler clears its flags as it returns
  task automatic lv(input logic [63:0] m);
    @(posedge clk);
    irq <= m;
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    hold(2);
  endtask
  task automatic quiet(input logic [63:0] m, input logic g);
    @(posedge clk);
    irq <= m;
    ge <= g;
    repeat (20) @(posedge clk);
    #1;
    chk("request", 8'h00, {7'h00, req});
  endtask
  task automatic s_static;
    wreg(2'h1, 8'hff);
    rreg(2'h1, 8'h00);
    srv(64'h220, 8'h05);
    rreg(2'h1, 8'h01);
    lv(64'h200);
    srv(64'h200, 8'h09);
    lv(64'h0);
  endtask
  task automatic s_high;
    wreg(2'h3, 8'h09);
    srv(64'h20, 8'h05);
    srv(64'h220, 8'h09);
    rreg(2'h1, 8'h03);
    lv(64'h20);
    rreg(2'h1, 8'h01);
    lv(64'h0);
    wreg(2'h3, 8'h00);
  endtask
  task automatic s_nmi;
    quiet(64'h80, 1'b0);
    srv(64'h82, 8'h01);
    rreg(2'h1, 8'h80);
    lv(64'h82);
    srv(64'h82, 8'h01);
    quiet(64'h82, 1'b1);
    lv(64'h80);
    srv(64'h80, 8'h07);
    lv(64'h0);
  endtask
  task automatic s_rotate;
    slow <= 1'b1;
    wreg(2'h2, 8'h05);
    srv(64'h88, 8'h07);
    lv(64'h8);
    srv(64'h8, 8'h03);
    lv(64'h0);
    rreg(2'h2, 8'h05);
    wreg(2'h0, 8'h01);
    wreg(2'h2, 8'h00);
    srv(64'h88, 8'h03);
    rreg(2'h2, 8'h03);
    lv(64'h88);
    srv(64'h88, 8'h07);
    lv(64'h0);
    wreg(2'h0, 8'h00);
    slow <= 1'b0;
  endtask
  // taken while asleep: waits for start-up, then five extra cycles
  task automatic s_sleep;
    @(posedge clk);
    sleep <= 1'b1;
    irq <= 64'h10;
    repeat (10) @(posedge clk);
    #1;
    chk("request", 8'h00, {7'h00, req});
    @(posedge clk);
    wake <= 1'b1;
    sleep <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    chk("wake delay", 8'h00, {7'h00, req});
    @(posedge clk);
    wake <= 1'b0;
    #1;
    chk("wake request", 8'h01, {7'h00, req});
    chk("vector", 8'h04, vec);
    hold(1);
    lv(64'h0);
  endtask
  task automatic s_compact;
    wreg(2'h0, 8'h60);
    #1;
    chk("placement", 8'h01, {7'h00, place});
    srv(64'h40, 8'h03);
    chk("raw vector", 8'h06, last);
    lv(64'h0);
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    ge <= 1'b1;
    s_static();
    s_high();
    s_nmi();
    s_rotate();
    s_sleep();
    s_compact();
    close_out();
  end
endmodule
bind cipr_top cipr_top_sva #(.FLASH_KB(FLASH_KB), .WIDE_PC(WIDE_PC))
  u_sva (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .ACK_I(ACK_I),
  .RET_I(RET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .REQ_O(REQ_O), .VEC_O(VEC_O),
  .HANDLER_JUMP_O(HANDLER_JUMP_O), .RET_DONE_O(RET_DONE_O),
  .PLACEMENT_O(PLACEMENT_O));
